// >>> include/aats_params.svh
// How it works
// RULE1: Start/stop mode is active only when the input configuration field equals 12.
// RULE2: Start is issued once the compared value rises strictly above the start threshold.
// RULE3: Stop is issued whenever the compared value is at or below the stop threshold.
// RULE4: An open terminal start input stops the drive and keeps it stopped.
// RULE5: An analog start is allowed only while the terminal start input is closed.
// RULE6: The feature works only when the terminal strip is the command source.
// RULE7: Comparisons use the offset-corrected value, never a gain-scaled one.
// RULE8: Diagnostic selector 10 shows the offset-corrected compared value.
// RULE9: Diagnostic selector 11 maps stop threshold, 12 start threshold, read and write.
// RULE10: Restore-defaults leaves both thresholds untouched.
// RULE11: Stop threshold defaults to 20 and accepts only 5 through 1023.
// RULE12: Start threshold defaults to 33 and accepts only 0 through 2000.
// RULE13: At or below stop threshold always stops, even if above start threshold.
// RULE14: Edge mode starts only on an off-to-on analog transition with permissives met.
// RULE15: Level mode starts whenever analog state is on and permissives are met.
// RULE16: In level mode a keypad stop blocks restart until a fresh off-to-on transition.
// RULE17: Analog off state stops the drive in either start mode.
// RULE18: Power module identification loads default values into both thresholds.
// RULE19: Offset is added to the raw 10-bit result before any gain.
// RULE20: Offset is signed and limited to -900 through +900 counts.
// RULE21: Analog state is a register: on above start, off at or below stop.
`ifndef AATS_PARAMS_SVH
`define AATS_PARAMS_SVH

`define AATS_OFS_CFG        8'h00
`define AATS_OFS_OFFSET     8'h04
`define AATS_OFS_DIAG_SEL   8'h08
`define AATS_OFS_DIAG_DATA  8'h0c
`define AATS_OFS_CMD        8'h10
`define AATS_OFS_STATUS     8'h14

`define AATS_CFG_MODE_LSB   0
`define AATS_CFG_SRC_LSB    4
`define AATS_CFG_LEVEL_BIT  8
`define AATS_CMD_RESTORE    0
`define AATS_CMD_IDENT      1

`define AATS_MODE_START_STOP 4'hc
`define AATS_SRC_TERMINAL    2'h0
`define AATS_DIAG_CORR       4'ha
`define AATS_DIAG_STOP       4'hb
`define AATS_DIAG_START      4'hc

`define AATS_RST_MODE       4'h0
`define AATS_RST_SRC        2'h0
`define AATS_RST_OFFSET     11'h000
`define AATS_RST_DIAG_SEL   4'h0
`define AATS_DEF_STOP       10'h014
`define AATS_DEF_START      11'h021
`define AATS_STOP_MIN       5
`define AATS_STOP_MAX       1023
`define AATS_START_MIN      0
`define AATS_START_MAX      2000
`define AATS_OFFSET_MIN     (-900)
`define AATS_OFFSET_MAX     900

`endif

// >>> include/aats_pkg.sv
package aats_pkg;

    typedef enum logic [0:0] {
        AATS_BUS_IDLE = 1'b0,
        AATS_BUS_ACK  = 1'b1
    } aats_bus_t;

    typedef struct packed {
        logic signed [11:0] corr;
    } aats_corr_st_t;

    typedef struct packed {
        logic analog_on;
    } aats_hyst_st_t;

    typedef struct packed {
        aats_bus_t          bus_st;
        logic               waitreq;
        logic        [31:0] rdata;
        logic        [3:0]  cfg_mode;
        logic        [1:0]  src;
        logic               level;
        logic signed [10:0] offset;
        logic        [3:0]  diag_sel;
        logic        [9:0]  stop_thr;
        logic        [10:0] start_thr;
        logic               kp_block;
        logic               an_prev;
        logic               run;
    } aats_top_st_t;

endpackage

// >>> design/aats_offset_corr.sv
`timescale 1ns/1ns
`default_nettype none
module aats_offset_corr #(
    parameter int ADC_W = 10
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [ADC_W-1:0]   raw_i,
    input  wire logic signed [10:0] offset_i,
    output logic signed [11:0]      corr_o
);
    aats_pkg::aats_corr_st_t r;
    aats_pkg::aats_corr_st_t r_nxt;

    // No gain is applied anywhere in this design, so the compare path never sees it
    always_comb begin
        r_nxt = r;
        r_nxt.corr = $signed({1'b0, raw_i}) + 12'(offset_i); // RULE19 RULE7
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign corr_o = r.corr;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_corr_sum: assert property ( // RULE19
        ##1 corr_o == $signed({1'b0, $past(raw_i)}) + 12'($past(offset_i)))
        else $error("Corrected value is not raw plus offset");
endmodule
`default_nettype wire

// >>> design/aats_hyst.sv
`timescale 1ns/1ns
`default_nettype none
module aats_hyst (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic signed [11:0] corr_i,
    input  wire logic [9:0]         stop_thr_i,
    input  wire logic [10:0]        start_thr_i,
    output logic                    analog_on_o
);
    aats_pkg::aats_hyst_st_t r;
    aats_pkg::aats_hyst_st_t r_nxt;
    logic at_stop;
    logic above_start;

    assign at_stop     = corr_i <= $signed({2'h0, stop_thr_i});  // RULE3
    assign above_start = corr_i > $signed({1'b0, start_thr_i});  // RULE2

    // Stop is checked first so an overlapping band always ends in off
    always_comb begin
        r_nxt = r;
        if (at_stop) begin
            r_nxt.analog_on = 1'b0; // RULE13 RULE21
        end else if (above_start) begin
            r_nxt.analog_on = 1'b1; // RULE21
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign analog_on_o = r.analog_on;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_stop_wins: assert property (at_stop |=> !analog_on_o) // RULE13
        else $error("Analog state on at or below stop threshold");
    a_start_sets: assert property (above_start && !at_stop |=> analog_on_o) // RULE2
        else $error("Analog state not on above start threshold");
    a_band_holds: assert property (!above_start && !at_stop |=> $stable(analog_on_o)) // RULE21
        else $error("Analog state moved inside hysteresis band");
endmodule
`default_nettype wire

// >>> design/aats_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "aats_params.svh"
module aats_top #(
    parameter int ADC_W = 10
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [7:0]       avs_address_i,
    input  wire logic             avs_read_i,
    input  wire logic             avs_write_i,
    input  wire logic [31:0]      avs_writedata_i,
    input  wire logic [3:0]       avs_byteenable_i,
    output logic [31:0]           avs_readdata_o,
    output logic                  avs_waitrequest_o,
    input  wire logic [ADC_W-1:0] adc_data_i,
    input  wire logic             term_start_closed_i,
    input  wire logic             term_stop_closed_i,
    input  wire logic             func_loss_closed_i,
    input  wire logic             keypad_stop_i,
    output logic                  analog_on_o,
    output logic                  run_o
);
    aats_pkg::aats_top_st_t r;
    aats_pkg::aats_top_st_t r_nxt;

    logic signed [11:0] corr;
    logic               analog_on;
    logic               req;
    logic               wr_take;
    logic               full_word;
    logic               enabled;
    logic               permit;
    logic               rise;
    logic               start_ok;
    logic               stop_now;
    logic signed [31:0] wval;

    function automatic logic aats_in_rng(input logic signed [31:0] v,
                                         input int lo,
                                         input int hi);
        aats_in_rng = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [31:0] aats_sext12(input logic signed [11:0] v);
        aats_sext12 = {{20{v[11]}}, v};
    endfunction

    aats_offset_corr #(
        .ADC_W (ADC_W)
    ) u_corr (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .raw_i    (adc_data_i),
        .offset_i (r.offset),
        .corr_o   (corr)
    );

    aats_hyst u_hyst (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .corr_i      (corr),
        .stop_thr_i  (r.stop_thr),
        .start_thr_i (r.start_thr),
        .analog_on_o (analog_on)
    );

    // A master that keeps its request up past the answer is served again
    assign req       = avs_read_i || avs_write_i;
    // A write lands only on the edge where waitrequest is seen low
    assign wr_take   = avs_write_i && (r.bus_st == aats_pkg::AATS_BUS_ACK);
    // Fields straddle byte lanes, so partial writes are dropped
    assign full_word = avs_byteenable_i == 4'hf;
    assign wval      = $signed(avs_writedata_i);

    assign enabled = (r.cfg_mode == `AATS_MODE_START_STOP) // RULE1
                  && (r.src == `AATS_SRC_TERMINAL);        // RULE6
    assign permit  = term_start_closed_i && term_stop_closed_i && func_loss_closed_i; // RULE5
    assign rise    = analog_on && !r.an_prev; // RULE14
    assign start_ok = enabled && permit
                   && (r.level ? (analog_on && !r.kp_block) // RULE15 RULE16
                               : rise);                     // RULE14
    // Any open permissive or analog off dominates a start in the same cycle
    assign stop_now = !enabled || !term_start_closed_i // RULE4
                   || !permit || !analog_on            // RULE17
                   || keypad_stop_i;

    always_comb begin
        r_nxt = r;
        r_nxt.an_prev = analog_on;

        // Keypad set wins over analog-off clear
        if (keypad_stop_i) begin
            r_nxt.kp_block = 1'b1; // RULE16
        end else if (!analog_on) begin
            r_nxt.kp_block = 1'b0; // RULE16
        end

        if (stop_now) begin
            r_nxt.run = 1'b0; // RULE3 RULE4 RULE17
        end else if (start_ok) begin
            r_nxt.run = 1'b1; // RULE2
        end

        // One wait cycle per access, one idle cycle before the next
        if (r.bus_st == aats_pkg::AATS_BUS_ACK) begin
            r_nxt.bus_st  = aats_pkg::AATS_BUS_IDLE;
            r_nxt.waitreq = 1'b1;
        end else if (req) begin
            r_nxt.bus_st  = aats_pkg::AATS_BUS_ACK;
            r_nxt.waitreq = 1'b0;
        end

        // Read data are latched when the request is taken, on the same edge that drops waitrequest
        if (req && r.bus_st == aats_pkg::AATS_BUS_IDLE) begin
            r_nxt.rdata = 32'h0;
            if (avs_read_i) begin
                case (avs_address_i)
                    `AATS_OFS_CFG: begin
                        r_nxt.rdata[`AATS_CFG_MODE_LSB +: 4] = r.cfg_mode;
                        r_nxt.rdata[`AATS_CFG_SRC_LSB +: 2]  = r.src;
                        r_nxt.rdata[`AATS_CFG_LEVEL_BIT]     = r.level;
                    end
                    `AATS_OFS_OFFSET: begin
                        r_nxt.rdata = {{21{r.offset[10]}}, r.offset};
                    end
                    `AATS_OFS_DIAG_SEL: begin
                        r_nxt.rdata[3:0] = r.diag_sel;
                    end
                    `AATS_OFS_DIAG_DATA: begin
                        case (r.diag_sel)
                            `AATS_DIAG_CORR:  r_nxt.rdata = aats_sext12(corr);  // RULE8
                            `AATS_DIAG_STOP:  r_nxt.rdata[9:0] = r.stop_thr;    // RULE9
                            `AATS_DIAG_START: r_nxt.rdata[10:0] = r.start_thr;  // RULE9
                            default:          r_nxt.rdata = 32'h0;
                        endcase
                    end
                    `AATS_OFS_STATUS: begin
                        r_nxt.rdata[0]     = r.run;
                        r_nxt.rdata[1]     = analog_on;
                        r_nxt.rdata[2]     = r.kp_block;
                        r_nxt.rdata[27:16] = corr;
                    end
                    default: begin
                        r_nxt.rdata = 32'h0;
                    end
                endcase
            end
        end

        if (wr_take && full_word) begin
            case (avs_address_i)
                `AATS_OFS_CFG: begin
                    r_nxt.cfg_mode = avs_writedata_i[`AATS_CFG_MODE_LSB +: 4];
                    r_nxt.src      = avs_writedata_i[`AATS_CFG_SRC_LSB +: 2];
                    r_nxt.level    = avs_writedata_i[`AATS_CFG_LEVEL_BIT];
                end
                `AATS_OFS_OFFSET: begin
                    if (aats_in_rng(wval, `AATS_OFFSET_MIN, `AATS_OFFSET_MAX)) begin
                        r_nxt.offset = wval[10:0]; // RULE20
                    end
                end
                `AATS_OFS_DIAG_SEL: begin
                    r_nxt.diag_sel = avs_writedata_i[3:0];
                end
                `AATS_OFS_DIAG_DATA: begin
                    case (r.diag_sel)
                        `AATS_DIAG_STOP: begin
                            if (aats_in_rng(wval, `AATS_STOP_MIN, `AATS_STOP_MAX)) begin
                                r_nxt.stop_thr = wval[9:0]; // RULE9 RULE11
                            end
                        end
                        `AATS_DIAG_START: begin
                            if (aats_in_rng(wval, `AATS_START_MIN, `AATS_START_MAX)) begin
                                r_nxt.start_thr = wval[10:0]; // RULE9 RULE12
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                `AATS_OFS_CMD: begin
                    // Thresholds survive a restore; only identification reloads them
                    if (avs_writedata_i[`AATS_CMD_RESTORE]) begin
                        r_nxt.cfg_mode = `AATS_RST_MODE; // RULE10
                        r_nxt.src      = `AATS_RST_SRC;
                        r_nxt.level    = 1'b0;
                        r_nxt.offset   = `AATS_RST_OFFSET;
                        r_nxt.diag_sel = `AATS_RST_DIAG_SEL;
                    end
                    if (avs_writedata_i[`AATS_CMD_IDENT]) begin
                        r_nxt.stop_thr  = `AATS_DEF_STOP;  // RULE18
                        r_nxt.start_thr = `AATS_DEF_START; // RULE18
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r           <= '0;
            r.bus_st    <= aats_pkg::AATS_BUS_IDLE;
            r.waitreq   <= 1'b1;
            r.cfg_mode  <= `AATS_RST_MODE;
            r.src       <= `AATS_RST_SRC;
            r.offset    <= `AATS_RST_OFFSET;
            r.diag_sel  <= `AATS_RST_DIAG_SEL;
            r.stop_thr  <= `AATS_DEF_STOP;  // RULE11
            r.start_thr <= `AATS_DEF_START; // RULE12
        end else begin
            r <= r_nxt;
        end
    end

    assign avs_readdata_o    = r.rdata;
    assign avs_waitrequest_o = r.waitreq;
    assign analog_on_o       = analog_on;
    assign run_o             = r.run;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_mode_gate: assert property ( // RULE1
        $rose(run_o) |-> $past(r.cfg_mode) == `AATS_MODE_START_STOP)
        else $error("Run started outside start/stop input mode");

    a_open_start: assert property ( // RULE4
        !term_start_closed_i |=> !run_o)
        else $error("Run high after terminal start opened");

    a_start_permit: assert property ( // RULE5
        $rose(run_o) |-> $past(term_start_closed_i && permit))
        else $error("Run started without permissives");

    a_src_gate: assert property ( // RULE6
        $rose(run_o) |-> $past(r.src) == `AATS_SRC_TERMINAL)
        else $error("Run started with another command source");

    a_diag_corr: assert property ( // RULE8
        avs_read_i && avs_address_i == `AATS_OFS_DIAG_DATA && !r.bus_st
        && r.diag_sel == `AATS_DIAG_CORR |=> avs_readdata_o == aats_sext12($past(corr)))
        else $error("Diagnostic read does not show corrected value");

    a_diag_thr: assert property ( // RULE9
        avs_read_i && avs_address_i == `AATS_OFS_DIAG_DATA && !r.bus_st
        && r.diag_sel == `AATS_DIAG_STOP |=> avs_readdata_o == {22'h0, r.stop_thr})
        else $error("Diagnostic read does not show stop threshold");

    a_restore_keep: assert property ( // RULE10
        wr_take && full_word && avs_address_i == `AATS_OFS_CMD
        && avs_writedata_i[`AATS_CMD_RESTORE] && !avs_writedata_i[`AATS_CMD_IDENT]
        |=> $stable(r.stop_thr) && $stable(r.start_thr))
        else $error("Restore defaults changed a threshold");

    a_stop_range: assert property ( // RULE11
        r.stop_thr >= 10'(`AATS_STOP_MIN))
        else $error("Stop threshold below its minimum");

    a_start_range: assert property ( // RULE12
        r.start_thr <= 11'(`AATS_START_MAX))
        else $error("Start threshold above its maximum");

    a_edge_start: assert property ( // RULE14
        $rose(run_o) && !$past(r.level) |-> $past(analog_on && !r.an_prev))
        else $error("Edge mode start without analog transition");

    a_level_start: assert property ( // RULE15
        r.level && enabled && permit && analog_on && !r.kp_block && !keypad_stop_i
        |=> run_o)
        else $error("Level mode failed to start");

    a_kp_block: assert property ( // RULE16
        r.level && keypad_stop_i ##1 analog_on [*2] |-> !run_o)
        else $error("Restart after keypad stop without new transition");

    a_off_stop: assert property ( // RULE17
        !analog_on |=> !run_o)
        else $error("Run high while analog state off");

    a_ident_load: assert property ( // RULE18
        wr_take && full_word && avs_address_i == `AATS_OFS_CMD
        && avs_writedata_i[`AATS_CMD_IDENT]
        |=> r.stop_thr == `AATS_DEF_STOP && r.start_thr == `AATS_DEF_START)
        else $error("Identification did not load default thresholds");

    a_offset_range: assert property ( // RULE20
        r.offset >= 11'sd0 - 11'sd900 && r.offset <= 11'sd900)
        else $error("Offset outside its range");

    a_bus_answer: assert property (
        req && r.bus_st == aats_pkg::AATS_BUS_IDLE |=> !avs_waitrequest_o)
        else $error("Bus answer not given after one wait cycle");

    // Waitrequest stays low for one cycle only per access
    a_wait_one: assert property (
        !avs_waitrequest_o
        |=> avs_waitrequest_o)
        else $error("Waitrequest low for more than one cycle");

    a_perm_stop: assert property ( // RULE5
        !(term_stop_closed_i && func_loss_closed_i)
        |=> !run_o)
        else $error("Run high with a permissive open");

    a_kp_stop: assert property ( // RULE16
        keypad_stop_i
        |=> !run_o && r.kp_block)
        else $error("Keypad stop did not stop and block");

    a_off_clear: assert property ( // RULE16
        !keypad_stop_i && !analog_on
        |=> !r.kp_block)
        else $error("Keypad block kept while analog state off");

    a_src_stop: assert property ( // RULE6
        r.src != `AATS_SRC_TERMINAL
        |=> !run_o)
        else $error("Run high with another command source");

    a_mode_stop: assert property ( // RULE1
        r.cfg_mode != `AATS_MODE_START_STOP
        |=> !run_o)
        else $error("Run high outside start/stop input mode");

    a_rd_hold: assert property (
        !req
        |=> $stable(avs_readdata_o))
        else $error("Read data changed without a request");

    a_cmd_read: assert property (
        avs_read_i && avs_address_i == `AATS_OFS_CMD && !r.bus_st
        |=> avs_readdata_o == 32'h0)
        else $error("Command register read not zero");

    c_edge_run: cover property (!r.level && $rose(run_o));
    c_level_run: cover property (r.level && $rose(run_o));
    c_kp_stop: cover property (r.level && keypad_stop_i && run_o);
    c_thr_write: cover property (wr_take && avs_address_i == `AATS_OFS_DIAG_DATA);
    c_kp_hold: cover property (r.level && r.kp_block && analog_on);
endmodule
`default_nettype wire

// >>> tb/aats_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module aats_far_model #(
    parameter int ADC_W = 10
) (
    input  wire logic        clk_i,
    output logic [ADC_W-1:0] adc_data_o,
    output logic             term_start_o,
    output logic             term_stop_o,
    output logic             func_loss_o
);
    // Pins start closed so the bench decides when a permissive is missing
    initial begin
        adc_data_o   = '0;
        term_start_o = 1'b1;
        term_stop_o  = 1'b1;
        func_loss_o  = 1'b1;
    end

    // Converter result only moves just after an edge, like a registered converter
    task automatic set_adc(input logic [ADC_W-1:0] v);
        @(posedge clk_i);
        adc_data_o <= v;
    endtask

    task automatic set_pins(input logic s, input logic p, input logic f);
        @(posedge clk_i);
        term_start_o <= s;
        term_stop_o  <= p;
        func_loss_o  <= f;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_analog_threshold_start_stop.sv
`timescale 1ns/1ns
`default_nettype none
`include "aats_params.svh"
module tb_analog_threshold_start_stop;
    logic        clk_i, rst_i, avs_read_i, avs_write_i, keypad_stop_i;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [3:0]  avs_byteenable_i;
    logic        avs_waitrequest_o, analog_on_o, run_o, ts, tp, fl, e;
    logic [9:0]  adc;
    int          n_fail, n_compared, cyc, i, v, off;
    logic [3:0]  tsel [7] = '{4'hb, 4'hb, 4'hb, 4'hb, 4'hc, 4'hc, 4'hc};
    logic [31:0] tval [7] = '{32'h4, 32'h400, 32'h5, 32'h3ff, 32'h7d1, 32'h7d0, 32'h0};
    logic [31:0] texp [7] = '{32'h14, 32'h14, 32'h5, 32'h3ff, 32'h21, 32'h7d0, 32'h0};

    aats_far_model i_far (.clk_i(clk_i), .adc_data_o(adc), .term_start_o(ts),
                          .term_stop_o(tp), .func_loss_o(fl));
    aats_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .adc_data_i(adc), .term_start_closed_i(ts),
        .term_stop_closed_i(tp), .func_loss_closed_i(fl), .keypad_stop_i(keypad_stop_i),
        .analog_on_o(analog_on_o), .run_o(run_o));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles; the ceiling leaves ample margin
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request stays up until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] r);
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        avs_write_i      <= w;
        avs_read_i       <= ~w;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, 4'hf, dummy);
    endtask

    task automatic thr_set(input logic [3:0] s, input logic [31:0] d);
        wr(`AATS_OFS_DIAG_SEL, {28'h0, s});
        wr(`AATS_OFS_DIAG_DATA, d);
    endtask

    task automatic thr_rd(input logic [3:0] s, output logic [31:0] r);
        wr(`AATS_OFS_DIAG_SEL, {28'h0, s});
        bus(1'b0, `AATS_OFS_DIAG_DATA, 32'h0, 4'hf, r);
    endtask

    // Raw change reaches run within three edges; six leaves settle margin
    task automatic pins(input logic [9:0] a, input logic on, input logic rn);
        i_far.set_adc(a);
        repeat (6) @(posedge clk_i);
        chk({30'h0, analog_on_o, run_o}, {30'h0, on, rn});
    endtask

    function automatic logic hyst(input int c, input int sp, input int st, input logic p);
        if (c <= sp) return 1'b0;
        if (c > st) return 1'b1;
        return p;
    endfunction

    initial begin
        rst_i = 1'b1;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 8'h00;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'hf;
        keypad_stop_i = 1'b0;
        cyc = 0;
        n_fail = 0;
        n_compared = 0;
        void'($urandom(32'hd228c972));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        thr_rd(4'hb, q); chk(q, 32'h14);
        thr_rd(4'hc, q); chk(q, 32'h21);
        bus(1'b0, 8'h20, 32'h0, 4'hf, q); chk(q, 32'h0);
        $display("reset values done");
        for (i = 0; i < 7; i++) begin
            thr_set(tsel[i], tval[i]);
            thr_rd(tsel[i], q); chk(q, texp[i]);
        end
        // Partial write must be ignored even with a legal value
        bus(1'b1, `AATS_OFS_DIAG_DATA, 32'h4d, 4'h3, q);
        thr_rd(4'hc, q); chk(q, 32'h0);
        wr(`AATS_OFS_OFFSET, 32'hfffffc7b);
        bus(1'b0, `AATS_OFS_OFFSET, 32'h0, 4'hf, q); chk(q, 32'h0);
        wr(`AATS_OFS_OFFSET, 32'hfffffc7c);
        wr(`AATS_OFS_OFFSET, 32'h385);
        bus(1'b0, `AATS_OFS_OFFSET, 32'h0, 4'hf, q); chk(q, 32'hfffffc7c);
        $display("ranges done");
        for (i = 0; i < 8; i++) begin
            v = $urandom_range(0, 1023);
            off = int'($urandom_range(0, 1800)) - 900;
            wr(`AATS_OFS_OFFSET, off);
            i_far.set_adc(v[9:0]);
            repeat (3) @(posedge clk_i);
            thr_rd(4'ha, q); chk(q, v + off);
        end
        $display("corrected view done");
        thr_set(4'hb, 32'h64);
        thr_set(4'hc, 32'hc8);
        wr(`AATS_OFS_CFG, 32'h10c);
        wr(`AATS_OFS_CMD, 32'h1);
        bus(1'b0, `AATS_OFS_CFG, 32'h0, 4'hf, q); chk(q, 32'h0);
        thr_rd(4'hb, q); chk(q, 32'h64);
        thr_rd(4'hc, q); chk(q, 32'hc8);
        wr(`AATS_OFS_CMD, 32'h2);
        thr_rd(4'hb, q); chk(q, 32'h14);
        thr_rd(4'hc, q); chk(q, 32'h21);
        $display("restore and identify done");
        wr(`AATS_OFS_OFFSET, 32'hfffffff6);
        wr(`AATS_OFS_CFG, 32'h00c);
        pins(10'd30, 1'b0, 1'b0);
        pins(10'd43, 1'b0, 1'b0);
        pins(10'd44, 1'b1, 1'b1);
        pins(10'd31, 1'b1, 1'b1);
        pins(10'd30, 1'b0, 1'b0);
        pins(10'd60, 1'b1, 1'b1);
        i_far.set_pins(1'b0, 1'b1, 1'b1);
        pins(10'd60, 1'b1, 1'b0);
        i_far.set_pins(1'b1, 1'b1, 1'b1);
        pins(10'd60, 1'b1, 1'b0);
        pins(10'd10, 1'b0, 1'b0);
        pins(10'd60, 1'b1, 1'b1);
        i_far.set_pins(1'b1, 1'b1, 1'b0);
        pins(10'd60, 1'b1, 1'b0);
        i_far.set_pins(1'b1, 1'b1, 1'b1);
        $display("edge mode done");
        wr(`AATS_OFS_CFG, 32'h10c);
        i_far.set_pins(1'b0, 1'b1, 1'b1);
        pins(10'd60, 1'b1, 1'b0);
        i_far.set_pins(1'b1, 1'b1, 1'b1);
        pins(10'd60, 1'b1, 1'b1);
        @(posedge clk_i);
        keypad_stop_i <= 1'b1;
        @(posedge clk_i);
        keypad_stop_i <= 1'b0;
        pins(10'd60, 1'b1, 1'b0);
        pins(10'd10, 1'b0, 1'b0);
        pins(10'd60, 1'b1, 1'b1);
        wr(`AATS_OFS_CFG, 32'h10b);
        pins(10'd60, 1'b1, 1'b0);
        wr(`AATS_OFS_CFG, 32'h11c);
        pins(10'd60, 1'b1, 1'b0);
        $display("level mode done");
        wr(`AATS_OFS_CFG, 32'h10c);
        thr_set(4'hb, 32'h64);
        thr_set(4'hc, 32'h32);
        pins(10'd80, 1'b0, 1'b0);
        pins(10'd130, 1'b1, 1'b1);
        bus(1'b0, `AATS_OFS_STATUS, 32'h0, 4'hf, q); chk(q, 32'h00780003);
        wr(`AATS_OFS_CMD, 32'h2);
        pins(10'd0, 1'b0, 1'b0);
        e = 1'b0;
        for (i = 0; i < 24; i++) begin
            v = $urandom_range(0, 80);
            e = hyst(v - 10, 20, 33, e);
            pins(v[9:0], e, e);
        end
        $display("random hysteresis done");
        wrap_up();
    end
endmodule
`default_nettype wire
